// File: logic/swd_top.sv
`timescale 1ns/100ps
// Overview of operation
// R1: Timeout period chosen at build time among 3.4 ms, 6.3 ms, 102 ms, 1.6 s.
// R2: Counter starts at reset release; timeout output goes low on expiry.
// R3: Host must toggle kick input before each timeout period ends.
// R4: Any change of the timeout output clears the counter.
// R5: A high pulse on the disable input clears the counter.
// R6: Rising kick edge clears always; falling edge too in dual-edge builds.
// R7: Kick pulses of 1 us are seen; glitches under 100 ns ignored.
// R8: Static kick with disable low makes the output toggle continuously.
// R9: Dual-edge builds hold the output low for the full assertion period.
// R10: Single-edge builds hold low at least 10 us, at most assertion period.
// R11: Output is active low, open-drain or push-pull by build choice.
// R12: Watchdog acts only while disable is low; undriven counts as low.
// R13: Disable high at startup keeps output high while high plus one period.
// R14: Disable high forces output high, but a low pulse lasts 10 us minimum.
// R15: Disable pulses of 1 us are seen; glitches under 100 ns ignored.
// R16: Timing starts after reset whatever the kick level.
// R17: All durations derive from counters on the internal clock.
// R18: Kick and disable are synchronised before any edge or width check.
module swd_top #(
  parameter logic [1:0]  TMO_SEL    = swd_pkg::TMO_SEL_DEF,
  parameter bit          DUAL_EDGE  = 1'b1,
  parameter bit          OPEN_DRAIN = 1'b0,
  parameter int unsigned TMO0_CYC   = swd_pkg::TMO0_CYC,
  parameter int unsigned TMO1_CYC   = swd_pkg::TMO1_CYC,
  parameter int unsigned TMO2_CYC   = swd_pkg::TMO2_CYC,
  parameter int unsigned TMO3_CYC   = swd_pkg::TMO3_CYC,
  parameter int unsigned ASSERT_CYC = swd_pkg::ASSERT_CYC,
  parameter int unsigned MIN_LOW_CYC = swd_pkg::MIN_LOW_CYC,
  parameter int unsigned GLITCH_CYC = swd_pkg::GLITCH_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // Host side inputs
  input  wire logic kick_input,
  input  wire logic disable_n,
  // Timeout output pin
  output logic      timeout_output_n,
  output logic      timeout_output_oe
);

  localparam int CW = swd_pkg::CNT_W;

  // ****************************************
  // Build-time selection and checks
  // ****************************************
  function automatic int unsigned sel_tmo(input logic [1:0] sel);
    case (sel)
      2'h0:    sel_tmo = TMO0_CYC;
      2'h1:    sel_tmo = TMO1_CYC;
      2'h2:    sel_tmo = TMO2_CYC;
      default: sel_tmo = TMO3_CYC;
    endcase
  endfunction : sel_tmo

  localparam int unsigned TMO_CYC = sel_tmo(TMO_SEL);           // [R1]

  if (TMO_CYC < 2 || TMO_CYC >= (64'h1 << CW)) begin : g_chk_tmo
    $error("swd_top: timeout count does not fit counter");
  end
  if (ASSERT_CYC < MIN_LOW_CYC || MIN_LOW_CYC < 1 ||
      ASSERT_CYC >= (64'h1 << CW)) begin : g_chk_assert
    $error("swd_top: assertion period shorter than low floor");
  end

  // ****************************************
  // Filtered inputs
  // ****************************************
  swd_pkg::swd_edge_s kick_f;
  swd_pkg::swd_edge_s dis_f;

  swd_filter #(
    .STABLE_CYC (GLITCH_CYC)
  ) u_kick_filter (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .pin_i    (kick_input),
    .edge_o   (kick_f)
  );

  swd_filter #(
    .STABLE_CYC (GLITCH_CYC)
  ) u_dis_filter (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .pin_i    (disable_n),
    .edge_o   (dis_f)
  );

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_ASSERT = 3'b010,
    ST_HOLD   = 3'b100
  } swd_state_e;

  typedef struct packed {
    swd_state_e    st;
    logic [CW-1:0] cnt;
    logic          out_n;
  } swd_top_s;

  swd_top_s top_q;
  swd_top_s top_d;

  logic kick_clr;
  logic low_done;

  assign kick_clr = kick_f.rise | (DUAL_EDGE & kick_f.fall);    // [R6]
  assign low_done = top_q.cnt >= CW'(MIN_LOW_CYC - 1);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    top_d = top_q;
    case (top_q.st)
      ST_RUN: begin
        top_d.out_n = 1'b1;
        if (dis_f.level) begin
          top_d.st  = ST_HOLD;                                  // [R12]
          top_d.cnt = '0;                                       // [R5]
        end else if (kick_clr) begin
          top_d.cnt = '0;                                       // [R6] [R3]
        end else if (top_q.cnt == CW'(TMO_CYC - 1)) begin
          top_d.st    = ST_ASSERT;
          top_d.out_n = 1'b0;                                   // [R2]
          top_d.cnt   = '0;                                     // [R4]
        end else begin
          top_d.cnt = top_q.cnt + CW'(1);                       // [R17]
        end
      end
      ST_ASSERT: begin
        top_d.cnt = top_q.cnt + CW'(1);
        if (dis_f.level && low_done) begin
          top_d.st    = ST_HOLD;                                // [R14]
          top_d.out_n = 1'b1;
          top_d.cnt   = '0;
        end else if (!DUAL_EDGE && kick_f.rise && low_done &&
                     !dis_f.level) begin
          top_d.st    = ST_RUN;                                 // [R10]
          top_d.out_n = 1'b1;
          top_d.cnt   = '0;                                     // [R4]
        end else if (top_q.cnt == CW'(ASSERT_CYC - 1)) begin
          top_d.st    = dis_f.level ? ST_HOLD : ST_RUN;         // [R9] [R8]
          top_d.out_n = 1'b1;
          top_d.cnt   = '0;                                     // [R4]
        end
      end
      ST_HOLD: begin
        top_d.out_n = 1'b1;
        top_d.cnt   = '0;
        if (!dis_f.level) begin
          top_d.st = ST_RUN;                                    // [R13] [R5]
        end
      end
      default: begin
        top_d.st    = ST_RUN;
        top_d.cnt   = '0;
        top_d.out_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      top_q.st    <= ST_RUN;                                    // [R16]
      top_q.cnt   <= '0;
      top_q.out_n <= 1'b1;
    end else if (clk_en) begin
      top_q <= top_d;
    end
  end

  // ****************************************
  // Output stage
  // ****************************************
  assign timeout_output_n  = OPEN_DRAIN ? 1'b0 : top_q.out_n;   // [R11]
  assign timeout_output_oe = OPEN_DRAIN ? !top_q.out_n : 1'b1;

endmodule : swd_top

// File: inc/swd_pkg.sv
// ****************************************
// Shared constants and carriers
// ****************************************
package swd_pkg;

  // ****************************************
  // Clock
  // ****************************************
  localparam real CLK_PERIOD_NS = 10.0;

  // ****************************************
  // Timeout periods, selectable at build time
  // ****************************************
  localparam real TMO0_MS = 3.4;
  localparam real TMO1_MS = 6.3;
  localparam real TMO2_MS = 102.0;
  localparam real TMO3_MS = 1600.0;
  localparam int unsigned TMO0_CYC =
    int'($floor(TMO0_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned TMO1_CYC =
    int'($floor(TMO1_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned TMO2_CYC =
    int'($floor(TMO2_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned TMO3_CYC =
    int'($floor(TMO3_MS * 1.0e6 / CLK_PERIOD_NS));

  // ****************************************
  // Assertion period and low pulse floor
  // ****************************************
  localparam real ASSERT_PERIOD_MS = 1.0;
  localparam int unsigned ASSERT_CYC =
    int'($floor(ASSERT_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam real MIN_LOW_US = 10.0;
  localparam int unsigned MIN_LOW_CYC =
    int'($ceil(MIN_LOW_US * 1.0e3 / CLK_PERIOD_NS));

  // ****************************************
  // Input glitch filter
  // ****************************************
  localparam real GLITCH_NS = 100.0;
  localparam int unsigned GLITCH_CYC =
    int'($ceil(GLITCH_NS / CLK_PERIOD_NS));
  localparam int GLITCH_W = 8;

  // ****************************************
  // Counter width and timeout select
  // ****************************************
  localparam int CNT_W = 28;
  localparam logic [1:0] TMO_SEL_DEF = 2'h0;

  // ****************************************
  // Filtered input carrier
  // ****************************************
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } swd_edge_s;

endpackage : swd_pkg

// File: logic/swd_filter.sv
`timescale 1ns/100ps
// ****************************************
// Synchroniser and glitch filter
// ****************************************
module swd_filter #(
  parameter int unsigned STABLE_CYC = swd_pkg::GLITCH_CYC
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // Raw pin
  input  wire logic              pin_i,
  // Filtered level and edges
  output swd_pkg::swd_edge_s     edge_o
);

  localparam int W = swd_pkg::GLITCH_W;

  typedef struct packed {
    logic [1:0]  sync;
    logic        cand;
    logic [W-1:0] cnt;
    logic        primed;
    logic        level;
    logic        rise;
    logic        fall;
  } swd_flt_s;

  swd_flt_s flt_q;
  swd_flt_s flt_d;

  if (STABLE_CYC < 1 || STABLE_CYC >= (1 << W)) begin : g_chk
    $error("swd_filter: STABLE_CYC out of range");
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    flt_d      = flt_q;
    flt_d.rise = 1'b0;
    flt_d.fall = 1'b0;
    flt_d.sync = {flt_q.sync[0], pin_i};                    // [R18]
    if (flt_q.sync[1] != flt_q.cand) begin
      flt_d.cand = flt_q.sync[1];
      flt_d.cnt  = '0;                                      // [R7] [R15]
    end else if (flt_q.cnt != W'(STABLE_CYC - 1)) begin
      flt_d.cnt = flt_q.cnt + W'(1);
    end else if (!flt_q.primed) begin
      flt_d.primed = 1'b1;
      flt_d.level  = flt_q.cand;                            // [R16]
    end else if (flt_q.cand != flt_q.level) begin
      flt_d.level = flt_q.cand;
      flt_d.rise  = flt_q.cand;
      flt_d.fall  = !flt_q.cand;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flt_q <= '0;
    end else if (clk_en) begin
      flt_q <= flt_d;
    end
  end

  assign edge_o = '{level: flt_q.level, rise: flt_q.rise,
                    fall: flt_q.fall};

endmodule : swd_filter

// File: tb/swd_checker.sv
`timescale 1ns/100ps
// ****
// Port checker
// ****
module swd_checker #(
  parameter int TMO_CYC = 200,
  parameter int ASR_CYC = 60,
  parameter int MIN_CYC = 10,
  parameter bit DUAL    = 1'b1,
  parameter bit OD      = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Pins
  input wire logic kick_input,
  input wire logic disable_n,
  input wire logic timeout_output_n,
  input wire logic timeout_output_oe
);
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic [15:0] qh_q;
  logic        kick_q;
  // Pin level as the host sees it, pull-up when released
  wire         out = timeout_output_oe ? timeout_output_n : 1'b1;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_q   <= '0;
      lo_q   <= '0;
      qh_q   <= '0;
      kick_q <= 1'b0;
    end else if (clk_en) begin
      hi_q   <= out ? hi_q + 16'h1 : 16'h0;
      lo_q   <= out ? 16'h0 : lo_q + 16'h1;
      qh_q   <= (out && !disable_n && kick_input == kick_q) ?
                qh_q + 16'h1 : 16'h0;
      kick_q <= kick_input;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_oe_push_pull: assert property
    (OD ? !timeout_output_n : timeout_output_oe)
    else $error("pin drive mode wrong");
  a_low_floor: assert property ($fell(out) |-> !out [*8])
    else $error("low pulse too short");
  a_low_min: assert property ($rose(out) |-> lo_q >= MIN_CYC)
    else $error("low pulse under floor");
  a_low_max: assert property (lo_q <= ASR_CYC)
    else $error("low pulse too long");
  a_dual_full: assert property
    (DUAL && $rose(out) && !disable_n |-> lo_q == ASR_CYC)
    else $error("dual low pulse not full length");
  a_no_early: assert property ($fell(out) |-> hi_q >= TMO_CYC - 1)
    else $error("timeout came early");
  a_expiry_bound: assert property (qh_q <= TMO_CYC + 16)
    else $error("no timeout without kick");
  a_disable_high: assert property
    ($rose(disable_n) ##1 disable_n [*8] ##1 disable_n [*8] ##1
     disable_n [*8] ##1 disable_n [*8] |-> out)
    else $error("disable did not force high");
  a_kick_ignored: assert property
    (DUAL && !out && !disable_n && lo_q < 16'd20 && kick_input != kick_q
     |=> !out [*8] ##1 !out [*8])
    else $error("kick ended dual low pulse");
  c_timeout: cover property ($fell(out));
  c_full: cover property ($rose(out) && lo_q == ASR_CYC);
  c_cut: cover property ($rose(out) && disable_n);
endmodule : swd_checker

bind swd_top swd_checker #(.TMO_CYC(TMO_CYC), .ASR_CYC(ASSERT_CYC),
  .MIN_CYC(MIN_LOW_CYC), .DUAL(DUAL_EDGE), .OD(OPEN_DRAIN)) chk_u (
  .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
  .kick_input(kick_input), .disable_n(disable_n),
  .timeout_output_n(timeout_output_n),
  .timeout_output_oe(timeout_output_oe));

// File: tb/swd_host.sv
`timescale 1ns/100ps
// ****
// Host model toggling the kick
// ****
module swd_host (
  // Clock
  input  wire logic core_clk,
  // Bench control
  input  wire logic run,
  input  wire logic glitch,
  // Kick pin
  output logic      kick
);
  logic tog_q = 1'b0;
  int   n     = 0;
  always @(posedge core_clk) begin // Kick well inside each period
    #1;
    n = run ? n + 1 : 0;
    if (n == 100) begin
      tog_q = ~tog_q;
      n = 0;
    end
  end
  assign kick = tog_q ^ glitch;
endmodule : swd_host

// File: tb/swd_top_tb.sv
`timescale 1ns/100ps
module swd_top_tb;
  localparam int TMO = 200;
  localparam int ASR = 60;
  localparam int MINL = 10;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        disable_n = 1'b0;
  logic        run = 1'b0;
  logic        glitch = 1'b0;
  logic        kick;
  logic        out_n;
  logic        oe;
  logic        kick_se = 1'b0;
  logic        out_se_n;
  logic        oe_se;
  // Open-drain pin with pull-up
  wire         se_pin = oe_se ? out_se_n : 1'b1;
  logic [15:0] n;
  int          num_errors = 0;
  int          tests_run = 0;
  swd_host host_u (.core_clk(core_clk), .run(run), .glitch(glitch),
    .kick(kick));
  swd_top #(.TMO0_CYC(TMO), .ASSERT_CYC(ASR), .MIN_LOW_CYC(MINL)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .kick_input(kick), .disable_n(disable_n),
    .timeout_output_n(out_n), .timeout_output_oe(oe));
  swd_top #(.TMO0_CYC(TMO), .ASSERT_CYC(ASR), .MIN_LOW_CYC(MINL),
    .DUAL_EDGE(1'b0), .OPEN_DRAIN(1'b1)) dut_se_u (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .kick_input(kick_se), .disable_n(disable_n),
    .timeout_output_n(out_se_n), .timeout_output_oe(oe_se));
  always #5 core_clk = ~core_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t: got %0d want %0d", $time, seen, exp);
    end
  endtask : check
  task automatic ticks(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : ticks
  task automatic meas(input logic v, input logic se = 1'b0);
    n = 0;
    while ((se ? se_pin : out_n) !== v && n < 16'd5000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 16'd5000) begin
      check(se ? se_pin : out_n, v);
    end
  endtask : meas
  task automatic t_period;
    meas(1'b0);
    check(n >= TMO - 2, 1'b1);
    meas(1'b1);
    check(n, ASR);
    meas(1'b0);
    check(n, TMO);
    meas(1'b1);
    check(n, ASR);
    ticks(50);
    clk_en = 1'b0;
    ticks(30);
    clk_en = 1'b1;
    meas(1'b0);
    check(n, TMO - 50);
    meas(1'b1);
    check(n, ASR);
  endtask : t_period
  task automatic t_kicks;
    run = 1'b1;
    ticks(1150);
    check(out_n, 1'b1);
    run = 1'b0;
    meas(1'b0);
    meas(1'b1);
    ticks(100);
    glitch = 1'b1;
    meas(1'b0);
    check(n > TMO, 1'b1);
  endtask : t_kicks
  task automatic t_glitch;
    meas(1'b1);
    ticks(100);
    glitch = 1'b0;
    ticks(5);
    glitch = 1'b1;
    meas(1'b0);
    check(n, TMO - 105);
  endtask : t_glitch
  task automatic t_low_kick;
    ticks(5);
    glitch = 1'b0;
    ticks(15);
    glitch = 1'b1;
    meas(1'b1);
    check(n, ASR - 20);
    meas(1'b0);
    check(n, TMO);
  endtask : t_low_kick
  task automatic t_disable(input logic boot);
    if (boot) begin
      reset_n = 1'b0;
      ticks(3);
      check(out_n, 1'b1);
      reset_n = 1'b1;
      ticks(50);
    end else begin
      ticks(5);
    end
    disable_n = 1'b1;
    meas(1'b1);
    check(n <= 16'd20, 1'b1);
    ticks(300);
    check(out_n, 1'b1);
    disable_n = 1'b0;
    meas(1'b0);
    check(n >= TMO, 1'b1);
  endtask : t_disable
  // Single-edge open-drain build; its pin fell with the main one
  task automatic t_single;
    check(oe_se, 1'b1);
    check(out_se_n, 1'b0);
    ticks(20);
    kick_se = 1'b1;
    meas(1'b1, 1'b1);
    // Filter latency plus sync and state update
    check(n, 16'(swd_pkg::GLITCH_CYC + 4));
    check(oe_se, 1'b0);
    meas(1'b0, 1'b1);
    check(n, TMO);
    meas(1'b1, 1'b1);
    check(n, ASR);
    ticks(100);
    kick_se = 1'b0;
    meas(1'b0, 1'b1);
    check(n, TMO - 100);
  endtask : t_single
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200us;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    check(out_n, 1'b1);
    check(oe, 1'b1);
    reset_n = 1'b1;
    t_period();
    t_kicks();
    t_glitch();
    t_low_kick();
    t_disable(1'b0);
    t_disable(1'b1);
    t_single();
    give_verdict();
  end
endmodule : swd_top_tb
